// ### verilog/cstr_pkg.sv
// constants for the capacitive sense timer routing block
//
// Contract
// (RULE_01) external path, alt select 1: timer0 counts sense oscillator
// (RULE_02) external path, alt select 0: timer0 counts its clock pin
// (RULE_03) source path 0: timer0 counts instruction clock, alt select ignored
// (RULE_04) timer1 clock select 11: timer1 counts sense oscillator
// (RULE_05) timer1 off when run 0; free when gate off; gated when both set
// (RULE_06) software never builds time base from the timer being sense-clocked
// (RULE_07) direction status reads 1 while sourcing, 0 while sinking current
// (RULE_08) software clears timer at time base start, captures count at end
// (RULE_09) software computes frequency as count divided by time base length
// (RULE_10) loaded measurement reuses same time base; expect a lower count
// (RULE_11) recommended time base: timer0 overflow toggling timer1 gate
// (RULE_12) software sets touch threshold between nominal and loaded counts
// (RULE_13) control0: enable b7, mode b6, b5-4 read zero, range b3-2, reset 0
// (RULE_14) sense oscillator runs and clocks timers only while enabled
// (RULE_15) variable mode range 00 gives no current; 01/10/11 low/mid/high
package cstr_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CSTR_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] CSTR_ADDR_T0CFG = 8'h04;
  localparam logic [7:0] CSTR_ADDR_T1CTL = 8'h08;
  localparam logic [7:0] CSTR_ADDR_T0CNT = 8'h0c;
  localparam logic [7:0] CSTR_ADDR_T1CNT = 8'h10;

  // ----------------------------------------------------------------
  // control0 field positions
  // ----------------------------------------------------------------
  localparam int CSTR_C0_EN     = 7;
  localparam int CSTR_C0_RM     = 6;
  localparam int CSTR_C0_RNG_LO = 2;
  localparam int CSTR_C0_DIR    = 1;
  localparam int CSTR_C0_TIMER0_ALT_CLOCK_SELECT  = 0;

  // ----------------------------------------------------------------
  // timer fields
  // ----------------------------------------------------------------
  localparam int CSTR_T0_PATH   = 0;  // timer0 source path select
  localparam int CSTR_T1_RUN    = 0;
  localparam int CSTR_T1_GE     = 1;
  localparam int CSTR_T1_GTGL   = 2;  // gate from timer0 overflow toggle
  localparam int CSTR_T1_CS_LO  = 6;
  localparam int CSTR_T0_OVF    = 8;  // overflow flag in count register

  localparam logic [1:0] CSTR_T1CS_INSTR = 2'h0;
  localparam logic [1:0] CSTR_T1CS_SYS   = 2'h1;
  localparam logic [1:0] CSTR_T1CS_OSC   = 2'h3;
  localparam logic [1:0] CSTR_RNG_NOISE  = 2'h0;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  CSTR_RST_CTRL0 = 8'h00;
  localparam logic        CSTR_RST_PATH  = 1'b0;
  localparam logic [7:0]  CSTR_RST_T1CTL = 8'h00;
  localparam logic [7:0]  CSTR_RST_T0CNT = 8'h00;
  localparam logic [15:0] CSTR_RST_T1CNT = 16'h0000;
  localparam int          CSTR_INSTR_DIV = 4;   // instruction clock = clk/4
  localparam logic [1:0]  CSTR_DIV_LAST  = 2'(CSTR_INSTR_DIV - 1);

endpackage : cstr_pkg

// ### verilog/cstr_top.sv
// capacitive sense timer routing: control register, timer0/timer1 clocking
`timescale 1ns/1ps

module cstr_top (
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SENSE_OSC_LEVEL,
  input  wire logic        TIMER0_EXT_CLOCK_PIN,
  input  wire logic        TIMER1_GATE_PIN,
  output logic             SENSE_MODULE_ENABLE,
  output logic             SENSE_REFERENCE_MODE,
  output logic      [1:0]  SENSE_CURRENT_RANGE,
  output logic             SENSE_CURRENT_ON,
  output logic             TIMER0_OVERFLOW
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]  osc_sync,  next_osc_sync;
  logic [1:0]  ext_sync,  next_ext_sync;
  logic [1:0]  gate_sync, next_gate_sync;
  logic        osc_prev,  next_osc_prev;
  logic        ext_prev,  next_ext_prev;
  logic [1:0]  div_cnt,   next_div_cnt;
  logic        c0_en,     next_c0_en;
  logic        c0_rm,     next_c0_rm;
  logic [1:0]  c0_rng,    next_c0_rng;
  logic        c0_timer0_alt_clock_select,  next_c0_timer0_alt_clock_select;
  logic        t0_path,   next_t0_path;
  logic [7:0]  t1_ctl,    next_t1_ctl;
  logic [7:0]  t0_cnt,    next_t0_cnt;
  logic        t0_ovf,    next_t0_ovf;
  logic [15:0] t1_cnt,    next_t1_cnt;
  logic        gate_tgl,  next_gate_tgl;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_cur_on;

  // decoded helpers
  logic        osc_edge;
  logic        ext_edge;
  logic        instr_tick;
  logic        t0_tick;
  logic        t1_tick;
  logic        t1_gate_ok;
  logic        osc_dir;
  logic        acc_done;
  logic        wr_en;
  logic        wr_t0;
  logic        wr_t1;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [1:0]  t1_cs;

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // pins are read only after the second sync stage
  assign osc_dir    = c0_en & osc_sync[1];                      // RULE_07
  assign osc_edge   = c0_en & osc_sync[1] & ~osc_prev;          // RULE_14
  assign ext_edge   = ext_sync[1] & ~ext_prev;
  assign instr_tick = (div_cnt == cstr_pkg::CSTR_DIV_LAST);
  assign t1_cs      = t1_ctl[cstr_pkg::CSTR_T1_CS_LO +: 2];

  // timer0 source routing
  always_comb begin
    if (!t0_path) begin
      t0_tick = instr_tick;                                     // RULE_03
    end else if (c0_timer0_alt_clock_select) begin
      t0_tick = osc_edge;                                       // RULE_01
    end else begin
      t0_tick = ext_edge;                                       // RULE_02
    end
  end

  // timer1 source routing and enable table
  always_comb begin
    case (t1_cs)
      cstr_pkg::CSTR_T1CS_INSTR: t1_tick = instr_tick;
      cstr_pkg::CSTR_T1CS_SYS:   t1_tick = 1'b1;
      cstr_pkg::CSTR_T1CS_OSC:   t1_tick = osc_edge;            // RULE_04
      default:                   t1_tick = 1'b0;
    endcase
    // toggle gate lets timer0 overflow frame the window
    if (t1_ctl[cstr_pkg::CSTR_T1_GTGL]) begin
      t1_gate_ok = gate_tgl;                                    // RULE_11
    end else begin
      t1_gate_ok = gate_sync[1];
    end
    if (!t1_ctl[cstr_pkg::CSTR_T1_RUN]) begin
      t1_tick = 1'b0;                                           // RULE_05
    end else if (t1_ctl[cstr_pkg::CSTR_T1_GE] && !t1_gate_ok) begin
      t1_tick = 1'b0;                                           // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign acc_done = PSEL & PENABLE & PREADY;
  assign wr_en    = acc_done & PWRITE;
  assign wr_t0    = wr_en & (PADDR == cstr_pkg::CSTR_ADDR_T0CNT);
  assign wr_t1    = wr_en & (PADDR == cstr_pkg::CSTR_ADDR_T1CNT);

  // read mux, unused bits read as zero
  always_comb begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (PADDR)
      cstr_pkg::CSTR_ADDR_CTRL0: begin
        rd_mux[7:0] = {c0_en, c0_rm, 2'h0, c0_rng,              // RULE_13
                       osc_dir, c0_timer0_alt_clock_select};
      end
      cstr_pkg::CSTR_ADDR_T0CFG: rd_mux[0]    = t0_path;
      cstr_pkg::CSTR_ADDR_T1CTL: rd_mux[7:0]  = t1_ctl;
      cstr_pkg::CSTR_ADDR_T0CNT: rd_mux[8:0]  = {t0_ovf, t0_cnt};
      cstr_pkg::CSTR_ADDR_T1CNT: rd_mux[15:0] = t1_cnt;
      default:                   addr_ok      = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_osc_sync  = {osc_sync[0], SENSE_OSC_LEVEL};
    next_ext_sync  = {ext_sync[0], TIMER0_EXT_CLOCK_PIN};
    next_gate_sync = {gate_sync[0], TIMER1_GATE_PIN};
    next_osc_prev  = osc_sync[1];
    next_ext_prev  = ext_sync[1];
    next_div_cnt   = instr_tick ? 2'h0 : div_cnt + 2'h1;
    next_c0_en     = c0_en;
    next_c0_rm     = c0_rm;
    next_c0_rng    = c0_rng;
    next_c0_timer0_alt_clock_select  = c0_timer0_alt_clock_select;
    next_t0_path   = t0_path;
    next_t1_ctl    = t1_ctl;
    next_gate_tgl  = gate_tgl;
    next_t0_ovf    = t0_ovf;
    // one wait cycle, then the answer stands for one cycle
    next_pready    = PSEL & PENABLE & ~PREADY;
    next_prdata    = PREADY ? 32'h0000_0000 : rd_mux;
    next_pslverr   = PSEL & PENABLE & ~PREADY & ~addr_ok;
    if (wr_en) begin
      case (PADDR)
        cstr_pkg::CSTR_ADDR_CTRL0: begin
          next_c0_en    = PWDATA[cstr_pkg::CSTR_C0_EN];         // RULE_13
          next_c0_rm    = PWDATA[cstr_pkg::CSTR_C0_RM];
          next_c0_rng   = PWDATA[cstr_pkg::CSTR_C0_RNG_LO +: 2];
          next_c0_timer0_alt_clock_select = PWDATA[cstr_pkg::CSTR_C0_TIMER0_ALT_CLOCK_SELECT];
        end
        cstr_pkg::CSTR_ADDR_T0CFG: begin
          next_t0_path = PWDATA[cstr_pkg::CSTR_T0_PATH];
        end
        cstr_pkg::CSTR_ADDR_T1CTL: begin
          next_t1_ctl = PWDATA[7:0];
        end
        cstr_pkg::CSTR_ADDR_T0CNT: begin
          if (PWDATA[cstr_pkg::CSTR_T0_OVF]) begin
            next_t0_ovf = 1'b0;    // write one to clear
          end
        end
        default: begin
        end
      endcase
    end
    // software load wins over a count edge so a clear is exact
    if (wr_t0) begin
      next_t0_cnt = PWDATA[7:0];                                // RULE_08
    end else if (t0_tick) begin
      next_t0_cnt = t0_cnt + 8'h01;
    end else begin
      next_t0_cnt = t0_cnt;
    end
    // a write to the count register blocks the overflow set, so the clear wins in the same cycle
    if (t0_tick && !wr_t0 && t0_cnt == 8'hff) begin
      next_t0_ovf   = 1'b1;
      next_gate_tgl = ~gate_tgl;                                // RULE_11
    end
    if (wr_t1) begin
      next_t1_cnt = PWDATA[15:0];                               // RULE_08
    end else if (t1_tick) begin
      next_t1_cnt = t1_cnt + 16'h0001;
    end else begin
      next_t1_cnt = t1_cnt;
    end
    // noise detection code supplies no charge current
    next_cur_on = next_c0_en &                                  // RULE_15
                  ~(next_c0_rm & (next_c0_rng == cstr_pkg::CSTR_RNG_NOISE));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_sync             <= 2'h0;
      ext_sync             <= 2'h0;
      gate_sync            <= 2'h0;
      osc_prev             <= 1'b0;
      ext_prev             <= 1'b0;
      div_cnt              <= 2'h0;
      c0_en                <= cstr_pkg::CSTR_RST_CTRL0[cstr_pkg::CSTR_C0_EN];
      c0_rm                <= cstr_pkg::CSTR_RST_CTRL0[cstr_pkg::CSTR_C0_RM];
      c0_rng               <= cstr_pkg::CSTR_RST_CTRL0[3:2];
      c0_timer0_alt_clock_select             <= cstr_pkg::CSTR_RST_CTRL0[0];
      t0_path              <= cstr_pkg::CSTR_RST_PATH;
      t1_ctl               <= cstr_pkg::CSTR_RST_T1CTL;
      t0_cnt               <= cstr_pkg::CSTR_RST_T0CNT;
      t0_ovf               <= 1'b0;
      t1_cnt               <= cstr_pkg::CSTR_RST_T1CNT;
      gate_tgl             <= 1'b0;
      PRDATA               <= 32'h0000_0000;
      PREADY               <= 1'b0;
      PSLVERR              <= 1'b0;
      SENSE_MODULE_ENABLE  <= 1'b0;
      SENSE_REFERENCE_MODE <= 1'b0;
      SENSE_CURRENT_RANGE  <= 2'h0;
      SENSE_CURRENT_ON     <= 1'b0;
      TIMER0_OVERFLOW      <= 1'b0;
    end else begin
      osc_sync             <= next_osc_sync;
      ext_sync             <= next_ext_sync;
      gate_sync            <= next_gate_sync;
      osc_prev             <= next_osc_prev;
      ext_prev             <= next_ext_prev;
      div_cnt              <= next_div_cnt;
      c0_en                <= next_c0_en;
      c0_rm                <= next_c0_rm;
      c0_rng               <= next_c0_rng;
      c0_timer0_alt_clock_select             <= next_c0_timer0_alt_clock_select;
      t0_path              <= next_t0_path;
      t1_ctl               <= next_t1_ctl;
      t0_cnt               <= next_t0_cnt;
      t0_ovf               <= next_t0_ovf;
      t1_cnt               <= next_t1_cnt;
      gate_tgl             <= next_gate_tgl;
      PRDATA               <= next_prdata;
      PREADY               <= next_pready;
      PSLVERR              <= next_pslverr;
      SENSE_MODULE_ENABLE  <= next_c0_en;                       // RULE_14
      SENSE_REFERENCE_MODE <= next_c0_rm;
      SENSE_CURRENT_RANGE  <= next_c0_rng;
      SENSE_CURRENT_ON     <= next_cur_on;
      TIMER0_OVERFLOW      <= next_t0_ovf;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  a_t0_osc_count: assert property ( // RULE_01
    t0_path && c0_timer0_alt_clock_select && osc_edge && !wr_t0 |=>
      t0_cnt == $past(t0_cnt) + 8'h01)
    else $error("timer0 missed a sense oscillator edge");

  a_t0_pin_count: assert property ( // RULE_02
    t0_path && !c0_timer0_alt_clock_select && !ext_edge && !wr_t0 |=>
      t0_cnt == $past(t0_cnt))
    else $error("timer0 counted without a pin edge");

  a_t0_instr_rate: assert property ( // RULE_03
    !t0_path && instr_tick && !wr_t0 ##1 (!t0_path && !wr_t0) [*3] |=>
      t0_cnt == $past(t0_cnt, 4) + 8'h01)
    else $error("timer0 not at instruction clock rate");

  a_t1_osc_count: assert property ( // RULE_04
    t1_cs == 2'h3 && t1_ctl[0] && !t1_ctl[1] && osc_edge && !wr_t1 |=>
      t1_cnt == $past(t1_cnt) + 16'h0001)
    else $error("timer1 missed a sense oscillator edge");

  a_t1_off_hold: assert property ( // RULE_05
    !t1_ctl[cstr_pkg::CSTR_T1_RUN] && !wr_t1 |=> $stable(t1_cnt))
    else $error("timer1 counted while off");

  a_dir_read: assert property ( // RULE_07
    PSEL && PENABLE && !PREADY && !PWRITE &&
    PADDR == cstr_pkg::CSTR_ADDR_CTRL0 |=> PRDATA[1] == $past(osc_dir))
    else $error("direction status not returned");

  a_ctrl_zero_bits: assert property ( // RULE_13
    PREADY && PADDR == cstr_pkg::CSTR_ADDR_CTRL0 |-> PRDATA[5:4] == 2'h0)
    else $error("unimplemented control bits read nonzero");

  // enable may be written in the next cycle, so only the current one counts
  a_off_no_edge: assert property ( // RULE_14
    !c0_en |-> !osc_edge && !SENSE_MODULE_ENABLE &&
      !(t1_cs == 2'h3 && t1_tick) && !(t0_path && c0_timer0_alt_clock_select && t0_tick))
    else $error("sense edge while module disabled");

  a_noise_no_current: assert property ( // RULE_15
    c0_rm && c0_rng == cstr_pkg::CSTR_RNG_NOISE |-> !SENSE_CURRENT_ON)
    else $error("current supplied in noise detection mode");

  c_t0_osc: cover property (t0_path && c0_timer0_alt_clock_select && t0_tick);
  c_t1_osc: cover property (t1_cs == 2'h3 && t1_tick);
  c_t0_ovf: cover property (t0_ovf && t1_ctl[cstr_pkg::CSTR_T1_GTGL]);
  c_bad_addr: cover property (PSLVERR);

endmodule : cstr_top

// ### tb/cstr_electrode_model.sv
// sense electrode model: oscillator whose rate drops under touch load
`timescale 1ns/1ps

module cstr_electrode_model #(
  parameter int HALF_NOM  = 50,  // half period untouched, ns
  parameter int HALF_LOAD = 70   // half period with finger load, ns
) (
  input  wire logic touched,
  input  wire logic freeze,
  input  wire logic freeze_level,
  output logic      osc_level
);
  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  // runs even while the block is disabled, so gating must be done inside
  initial begin
    osc_level = 1'b0;
    forever begin
      if (freeze) begin
        osc_level = freeze_level;  // parked to read direction status
        #10;
      end else begin
        #(touched ? HALF_LOAD : HALF_NOM);
        osc_level = ~osc_level;
      end
    end
  end
endmodule : cstr_electrode_model

// ### tb/cap_sense_timer_routing_bench.sv
// self-checking bench for the capacitive sense timer routing block
`timescale 1ns/1ps

module cap_sense_timer_routing_bench;
  logic        mclk, arst_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, osc, ext_pin, gate_pin;
  logic        en_o, rm_o, cur_on, t0_ovf;
  logic [1:0]  rng_o;
  logic        touched, freeze, freeze_lvl;
  int          checks, mismatches;
  logic [31:0] v, nom, ld;

  cstr_top dut_u (.MCLK(mclk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SENSE_OSC_LEVEL(osc), .TIMER0_EXT_CLOCK_PIN(ext_pin),
    .TIMER1_GATE_PIN(gate_pin), .SENSE_MODULE_ENABLE(en_o),
    .SENSE_REFERENCE_MODE(rm_o), .SENSE_CURRENT_RANGE(rng_o),
    .SENSE_CURRENT_ON(cur_on), .TIMER0_OVERFLOW(t0_ovf));

  cstr_electrode_model elec_u (.touched(touched), .freeze(freeze),
    .freeze_level(freeze_lvl), .osc_level(osc));

  // ----------------------------------------------------------------
  // clock and common tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string msg);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] inr(input logic [31:0] x,
                                      input int lo, input int hi);
    return (x >= lo && x <= hi) ? 32'h1 : 32'h0;
  endfunction : inr

  // one apb transfer; waits an edge first so signals never toggle twice
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // clear at start of a cycle-counted window, capture at its end
  task meas(input logic [7:0] a, input int n, output logic [31:0] r);
    wr(a, 32'h0);
    cyc(n);
    rd(a, r);
  endtask : meas

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [31:0] r;
    logic e;
    rd(cstr_pkg::CSTR_ADDR_CTRL0, r);
    check(r, 32'h0, "ctrl0 reset");
    rd(cstr_pkg::CSTR_ADDR_T1CTL, r);
    check(r, 32'h0, "t1ctl reset");
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({31'h0, e}, 32'h1, "unmapped err");
    check(r, 32'h0, "unmapped data");
  endtask : t_reset

  task t_ctrl;
    logic [31:0] r;
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'hffffffff);
    rd(cstr_pkg::CSTR_ADDR_CTRL0, r);
    check(r & 32'hfffffffd, 32'hcd, "ctrl0 fields");
    check({29'h0, en_o, rng_o}, 32'h7, "ctrl0 outputs");
    for (int m = 0; m < 2; m++) begin
      for (int g = 0; g < 4; g++) begin
        wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h80 | (m << 6) | (g << 2));
        cyc(2);
        check({31'h0, cur_on}, 32'(m != 1 || g != 0), "cur on");
        check({29'h0, rm_o, rng_o}, 32'(m * 4 + g), "mode range");
      end
    end
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h44);
    cyc(2);
    check({31'h0, cur_on}, 32'h0, "cur off disabled");
  endtask : t_ctrl

  task t_dir;
    logic [31:0] r;
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h80);
    for (int l = 1; l >= 0; l--) begin
      freeze <= 1'b1;
      freeze_lvl <= l[0];
      cyc(8);
      rd(cstr_pkg::CSTR_ADDR_CTRL0, r);
      check(r & 32'h2, 32'(l * 2), "direction");
    end
    freeze <= 1'b0;
  endtask : t_dir

  task t_timer0;
    logic [31:0] r;
    wr(cstr_pkg::CSTR_ADDR_T0CFG, 32'h1);
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h81);
    meas(cstr_pkg::CSTR_ADDR_T0CNT, 200, r);
    check(inr(r & 32'hff, 18, 23), 32'h1, "t0 sense count");
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h80);
    wr(cstr_pkg::CSTR_ADDR_T0CNT, 32'h0);
    repeat (5) begin
      ext_pin <= 1'b1;
      cyc(3);
      ext_pin <= 1'b0;
      cyc(3);
    end
    cyc(6);
    rd(cstr_pkg::CSTR_ADDR_T0CNT, r);
    check(r & 32'hff, 32'h5, "t0 pin count");
    wr(cstr_pkg::CSTR_ADDR_T0CFG, 32'h0);
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h81);
    meas(cstr_pkg::CSTR_ADDR_T0CNT, 40, r);
    check(inr(r & 32'hff, 9, 13), 32'h1, "t0 instr count");
  endtask : t_timer0

  task t_timer1;
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h80);
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'hc1);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 200, nom);
    check(inr(nom, 18, 23), 32'h1, "t1 nominal");
    touched <= 1'b1;
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 200, ld);
    check(inr(ld, 12, nom - 1), 32'h1, "t1 loaded lower");
    v = (nom + ld) / 2;
    check({31'h0, ld < v && nom > v}, 32'h1, "threshold");
    touched <= 1'b0;
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h0);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 100, v);
    check(v, 32'h0, "no count disabled");
  endtask : t_timer1

  task t_gate;
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'h02);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 40, v);
    check(v, 32'h0, "t1 off");
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'h01);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 40, v);
    check(inr(v, 9, 13), 32'h1, "t1 free");
    // system clock select ticks every cycle: load and capture edges excluded, the two read setup edges counted
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'h41);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 40, v);
    check(v, 32'h2a, "t1 system clock");
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'h81);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 40, v);
    check(v, 32'h0, "t1 no source");
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'h03);
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 40, v);
    check(v, 32'h0, "t1 gate closed");
    gate_pin <= 1'b1;
    meas(cstr_pkg::CSTR_ADDR_T1CNT, 40, v);
    check(inr(v, 8, 13), 32'h1, "t1 gate open");
    gate_pin <= 1'b0;
  endtask : t_gate

  // timer0 overflow toggles the timer1 gate, so windows alternate open/shut
  task t_tbase;
    logic [31:0] c [3];
    int          n;
    wr(cstr_pkg::CSTR_ADDR_CTRL0, 32'h80);
    wr(cstr_pkg::CSTR_ADDR_T1CTL, 32'hc7);
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (t0_ovf !== 1'b1 && n < 1200);
      if (t0_ovf !== 1'b1) begin
        mismatches++;
        results();
      end
      rd(cstr_pkg::CSTR_ADDR_T1CNT, c[i]);
      wr(cstr_pkg::CSTR_ADDR_T0CNT, 32'h100);
      cyc(1);
      check({31'h0, t0_ovf}, 32'h0, "overflow cleared");
    end
    c[0] = c[1] - c[0];
    c[1] = c[2] - c[1];
    if (c[0] < c[1]) begin
      c[2] = c[0];
      c[0] = c[1];
      c[1] = c[2];
    end
    check(inr(c[0], 95, 110), 32'h1, "gate open window");
    check(inr(c[1], 0, 2), 32'h1, "gate shut window");
  endtask : t_tbase

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, ext_pin, gate_pin} = 6'h0;
    {touched, freeze, freeze_lvl} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    checks = 0;
    mismatches = 0;
    cyc(4);
    arst_n <= 1'b1;
    t_reset();
    t_ctrl();
    t_dir();
    t_timer0();
    t_timer1();
    t_gate();
    t_tbase();
    results();
  end
endmodule : cap_sense_timer_routing_bench
